// file: include/hdpc_pkg.sv
// Constants shared by the downstream port control block
package hdpc_pkg;
	localparam int          NPORTS        = 4;
	localparam int          APB_AW        = 12;
	// Register indices; the byte address is four times the index
	localparam logic [7:0]  IDX_ENABLE    = 8'h49;
	localparam logic [7:0]  IDX_SPEED     = 8'h4A;
	localparam logic [7:0]  IDX_FORCE_CTL = 8'h4B;
	localparam logic [7:0]  IDX_SE0_STAT  = 8'h4F;
	localparam logic [7:0]  IDX_DIFF_DATA = 8'h50;
	localparam logic [7:0]  IDX_FORCE_LOW = 8'h51;
	// Values after reset
	localparam logic [3:0]  RST_ENABLE    = 4'h0;
	localparam logic [3:0]  RST_SPEED     = 4'h0;
	localparam logic [7:0]  RST_FORCE_CTL = 8'h00;
	localparam logic [7:0]  RST_FORCE_LOW = 8'h00;
	localparam logic [3:0]  RST_LINE      = 4'h0;
	// Field layout of the line force control register
	localparam int          FCTL_W        = 2;
	// Pin force low register: D+ of port i at bit 2i+1, D- at bit 2i
	localparam int          FLOW_DP_OFS   = 1;
	localparam int          FLOW_DM_OFS   = 0;

	typedef enum logic [1:0] {
		HDPC_FORCE_NONE,
		HDPC_FORCE_DIFF1,
		HDPC_FORCE_DIFF0,
		HDPC_FORCE_SE0
	} hdpc_force_e;

	// Register index of an APB byte address, with alignment check
	function automatic logic [8:0] hdpc_reg_index(input logic [APB_AW-1:0] addr);
		hdpc_reg_index = {addr[APB_AW-1:10] == 2'b00 && addr[1:0] == 2'b00, addr[9:2]};
	endfunction
endpackage

// file: rtl/hdpc_line_sense.sv
// Per port SE0 and differential data sensing with hold through SE0
`timescale 1ns/1ps
module hdpc_line_sense (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       usb_bus_reset,
	input  wire logic [3:0] dp,
	input  wire logic [3:0] dm,
	output logic      [3:0] se0_reg,
	output logic      [3:0] diff_reg
);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			se0_reg <= hdpc_pkg::RST_LINE;
		end else if (usb_bus_reset) begin
			se0_reg <= hdpc_pkg::RST_LINE;
		end else begin
			se0_reg <= ~dp & ~dm;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			diff_reg <= hdpc_pkg::RST_LINE;
		end else if (usb_bus_reset) begin
			diff_reg <= hdpc_pkg::RST_LINE;
		end else begin
			for (int i = 0; i < 4; i++) begin
				// Only a differential state updates; SE0 and SE1 keep the last one
				if (dp[i] != dm[i]) begin
					diff_reg[i] <= dp[i];
				end
			end
		end
	end
endmodule

// file: rtl/hdpc_port_ctrl.sv
// Downstream port enable, line forcing and line sensing for a four port hub repeater
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
// How it works
// - One enable bit per port, bits 0-3
// - Reset and bus reset clear all enables
// - Babble clears that port's enable bit
// - Non-idle traffic at EOF2 is babble
// - Upstream connectivity still open at EOF2 is babble
// - Two control bits per port, reset clears
// - 00 none, 01 J, 10 K, 11 SE0
// - Control forcing uses speed-based edge rate
// - Per-pin force low, D+ odd bits
// - Force low: no edge rate, held in suspend
// - Force low gives SE0 when unconfigured
// - Read-only SE0 flag per port
// - Read-only differential bit, speed independent
// - Differential bit holds through SE0
// - Reset and bus reset clear line status
// - Speed bit: 1 low, 0 full speed
// - Enable deferred until current packet ends
// - Repeat to enabled ports, no FS to LS
module hdpc_port_ctrl (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        usb_bus_reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        eof2_strobe,
	input  wire logic        pkt_busy,
	input  wire logic        upstream_fs_pkt,
	input  wire logic [3:0]  port_rx_active,
	input  wire logic [3:0]  port_conn_open,
	input  wire logic [3:0]  port_suspended,
	input  wire logic        dev_suspend,
	input  wire logic [3:0]  rep_drive,
	input  wire logic [3:0]  rep_dp,
	input  wire logic [3:0]  rep_dm,
	output logic      [3:0]  port_repeat_down_en,
	output logic      [3:0]  port_repeat_up_en,
	input  wire logic [3:0]  dp_in,
	input  wire logic [3:0]  dm_in,
	output logic      [3:0]  dp_out,
	output logic      [3:0]  dm_out,
	output logic      [3:0]  dp_oe_n,
	output logic      [3:0]  dm_oe_n,
	output logic      [3:0]  edge_ctl_en,
	output logic      [3:0]  edge_low_speed
);
	logic [3:0]  enable_reg;
	logic [3:0]  active_reg;
	logic [3:0]  speed_reg;
	logic [7:0]  force_ctl_reg;
	logic [7:0]  force_low_reg;
	logic [3:0]  se0_reg;
	logic [3:0]  diff_reg;
	logic [3:0]  dp_sync;
	logic [3:0]  dm_sync;
	logic [3:0]  babble_now;
	logic [8:0]  sel_idx;
	logic        addr_hit;
	logic        wr_byte0;
	logic [7:0]  rd_byte;
	logic [31:0] prdata_reg;
	logic [3:0]  dp_next;
	logic [3:0]  dm_next;
	logic [3:0]  dp_oe_n_next;
	logic [3:0]  dm_oe_n_next;
	logic [3:0]  edge_ctl_next;

	hdpc_sync3 #(
		.W (8)
	) u_pin_sync (
		.clk (clk),
		.rst (rst),
		.d   ({dp_in, dm_in}),
		.q   ({dp_sync, dm_sync})
	);

	hdpc_line_sense u_sense (
		.clk           (clk),
		.rst           (rst),
		.usb_bus_reset (usb_bus_reset),
		.dp            (dp_sync),
		.dm            (dm_sync),
		.se0_reg       (se0_reg),
		.diff_reg      (diff_reg)
	);

	// APB decode
	always_comb begin
		sel_idx  = hdpc_pkg::hdpc_reg_index(paddr);
		addr_hit = 1'b0;
		if (sel_idx[8]) begin
			if (sel_idx[7:0] == hdpc_pkg::IDX_ENABLE) begin
				addr_hit = 1'b1;
			end else if (sel_idx[7:0] == hdpc_pkg::IDX_SPEED) begin
				addr_hit = 1'b1;
			end else if (sel_idx[7:0] == hdpc_pkg::IDX_FORCE_CTL) begin
				addr_hit = 1'b1;
			end else if (sel_idx[7:0] == hdpc_pkg::IDX_SE0_STAT) begin
				addr_hit = 1'b1;
			end else if (sel_idx[7:0] == hdpc_pkg::IDX_DIFF_DATA) begin
				addr_hit = 1'b1;
			end else if (sel_idx[7:0] == hdpc_pkg::IDX_FORCE_LOW) begin
				addr_hit = 1'b1;
			end
		end
	end

	// Read mux; upper nibble of the 4-bit registers reads zero
	// reserved bits zero
	always_comb begin
		rd_byte = 8'h00;
		if (sel_idx[8]) begin
			if (sel_idx[7:0] == hdpc_pkg::IDX_ENABLE) begin
				rd_byte = {4'h0, enable_reg};
			end else if (sel_idx[7:0] == hdpc_pkg::IDX_SPEED) begin
				rd_byte = {4'h0, speed_reg};
			end else if (sel_idx[7:0] == hdpc_pkg::IDX_FORCE_CTL) begin
				rd_byte = force_ctl_reg;
			end else if (sel_idx[7:0] == hdpc_pkg::IDX_SE0_STAT) begin
				rd_byte = {4'h0, se0_reg};
			end else if (sel_idx[7:0] == hdpc_pkg::IDX_DIFF_DATA) begin
				rd_byte = {4'h0, diff_reg};
			end else if (sel_idx[7:0] == hdpc_pkg::IDX_FORCE_LOW) begin
				rd_byte = force_low_reg;
			end
		end
	end

	assign wr_byte0 = psel && penable && pwrite && pstrb[0];
	assign pready   = psel && penable;
	assign pslverr  = psel && penable && !addr_hit;
	assign prdata   = prdata_reg;

	// Read data is captured in the setup cycle and shown in the access cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_reg <= {24'h00_0000, rd_byte};
		end
	end

	assign babble_now = eof2_strobe ? (enable_reg & (port_rx_active | port_conn_open)) : 4'h0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enable_reg <= hdpc_pkg::RST_ENABLE;
		end else if (usb_bus_reset) begin
			enable_reg <= hdpc_pkg::RST_ENABLE;
		end else if (wr_byte0 && sel_idx == {1'b1, hdpc_pkg::IDX_ENABLE}) begin
			enable_reg <= pwdata[3:0] & ~babble_now;
		end else begin
			enable_reg <= enable_reg & ~babble_now;
		end
	end

	// enabling waits for the end of the current packet
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			active_reg <= hdpc_pkg::RST_ENABLE;
		end else if (usb_bus_reset) begin
			active_reg <= hdpc_pkg::RST_ENABLE;
		end else if (pkt_busy) begin
			active_reg <= active_reg & enable_reg & ~babble_now;
		end else begin
			active_reg <= enable_reg & ~babble_now;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			speed_reg <= hdpc_pkg::RST_SPEED;
		end else if (usb_bus_reset) begin
			speed_reg <= hdpc_pkg::RST_SPEED;
		end else if (wr_byte0 && sel_idx == {1'b1, hdpc_pkg::IDX_SPEED}) begin
			speed_reg <= pwdata[3:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			force_ctl_reg <= hdpc_pkg::RST_FORCE_CTL;
		end else if (usb_bus_reset) begin
			force_ctl_reg <= hdpc_pkg::RST_FORCE_CTL;
		end else if (wr_byte0 && sel_idx == {1'b1, hdpc_pkg::IDX_FORCE_CTL}) begin
			force_ctl_reg <= pwdata[7:0];
		end
	end

	// per-pin force low register, chip reset only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			force_low_reg <= hdpc_pkg::RST_FORCE_LOW;
		end else if (wr_byte0 && sel_idx == {1'b1, hdpc_pkg::IDX_FORCE_LOW}) begin
			force_low_reg <= pwdata[7:0];
		end
	end

	// repeat gating, no full-speed traffic to low-speed ports
	always_comb begin
		port_repeat_up_en   = active_reg & ~port_suspended;
		port_repeat_down_en = active_reg & ~port_suspended & ~(speed_reg & {4{upstream_fs_pkt}});
	end

	// Pin drive: force low beats control forcing, which beats repeated traffic
	always_comb begin
		dp_next       = 4'h0;
		dm_next       = 4'h0;
		dp_oe_n_next  = 4'hF;
		dm_oe_n_next  = 4'hF;
		edge_ctl_next = 4'h0;
		for (int i = 0; i < hdpc_pkg::NPORTS; i++) begin
			case (hdpc_pkg::hdpc_force_e'(force_ctl_reg[i*hdpc_pkg::FCTL_W +: hdpc_pkg::FCTL_W]))
				hdpc_pkg::HDPC_FORCE_DIFF1: begin
					dp_next[i] = 1'b1;
					dm_next[i] = 1'b0;
				end
				hdpc_pkg::HDPC_FORCE_DIFF0: begin
					dp_next[i] = 1'b0;
					dm_next[i] = 1'b1;
				end
				hdpc_pkg::HDPC_FORCE_SE0: begin
					dp_next[i] = 1'b0;
					dm_next[i] = 1'b0;
				end
				default: begin
					dp_next[i] = rep_dp[i];
					dm_next[i] = rep_dm[i];
				end
			endcase
			if (force_ctl_reg[i*hdpc_pkg::FCTL_W +: hdpc_pkg::FCTL_W] != 2'b00) begin
				edge_ctl_next[i] = 1'b1;
				dp_oe_n_next[i]  = 1'b0;
				dm_oe_n_next[i]  = 1'b0;
			end else if (rep_drive[i] && active_reg[i] && !dev_suspend) begin
				edge_ctl_next[i] = 1'b1;
				dp_oe_n_next[i]  = 1'b0;
				dm_oe_n_next[i]  = 1'b0;
			end
			// force low, raw drive, kept in suspend
			if (force_low_reg[2*i+hdpc_pkg::FLOW_DP_OFS]) begin
				dp_next[i]       = 1'b0;
				dp_oe_n_next[i]  = 1'b0;
				edge_ctl_next[i] = 1'b0;
			end
			if (force_low_reg[2*i+hdpc_pkg::FLOW_DM_OFS]) begin
				dm_next[i]       = 1'b0;
				dm_oe_n_next[i]  = 1'b0;
				edge_ctl_next[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dp_out         <= 4'h0;
			dm_out         <= 4'h0;
			dp_oe_n        <= 4'hF;
			dm_oe_n        <= 4'hF;
			edge_ctl_en    <= 4'h0;
			edge_low_speed <= 4'h0;
		end else begin
			dp_out         <= dp_next;
			dm_out         <= dm_next;
			dp_oe_n        <= dp_oe_n_next;
			dm_oe_n        <= dm_oe_n_next;
			edge_ctl_en    <= edge_ctl_next;
			edge_low_speed <= speed_reg;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_babble_clears_en: assert property ((babble_now != 4'h0 && !usb_bus_reset) |=>
		((enable_reg & $past(babble_now)) == 4'h0) && ((active_reg & $past(babble_now)) == 4'h0))
		else $error("babble did not clear enable");
	a_babble_cause: assert property (eof2_strobe && enable_reg[0] && port_conn_open[0] |-> babble_now[0])
		else $error("open connectivity at EOF2 not babble");
	a_bus_reset_clear: assert property (usb_bus_reset |=> enable_reg == 4'h0 && force_ctl_reg == 8'h00
		&& se0_reg == 4'h0 && diff_reg == 4'h0 && speed_reg == 4'h0)
		else $error("bus reset left state");
	a_enable_deferred: assert property (((active_reg & ~$past(active_reg)) != 4'h0) |-> !$past(pkt_busy))
		else $error("port enabled during a packet");
	a_enable_idle_now: assert property (!pkt_busy && !usb_bus_reset && babble_now == 4'h0 |=>
		active_reg == $past(enable_reg))
		else $error("idle enable not immediate");
	a_force_se0_pins: assert property (force_ctl_reg[1:0] == 2'b11 |=> !dp_out[0] && !dm_out[0]
		&& !dp_oe_n[0] && !dm_oe_n[0])
		else $error("forced SE0 not driven");
	a_force_j_pins: assert property (force_ctl_reg[1:0] == 2'b01 && force_low_reg[1:0] == 2'b00 |=>
		dp_out[0] && !dm_out[0] && edge_ctl_en[0])
		else $error("forced J not driven");
	a_force_low_pin: assert property (force_low_reg[1] |=> !dp_out[0] && !dp_oe_n[0] && !edge_ctl_en[0])
		else $error("force low D+ not driven low");
	a_diff_hold: assert property ((se0_reg[0] && !usb_bus_reset) ##1 se0_reg[0] |-> $stable(diff_reg[0]))
		else $error("diff data changed during SE0");
	a_enable_readback: assert property (psel && !penable && !pwrite && paddr == 12'h124 |=>
		prdata[31:4] == 28'h0 && prdata[3:0] == $past(enable_reg))
		else $error("enable read back wrong");
	a_no_fs_to_ls: assert property ((speed_reg & port_repeat_down_en & {4{upstream_fs_pkt}}) == 4'h0)
		else $error("full speed sent to low speed port");

	c_babble: cover property (babble_now != 4'h0);
	c_deferred: cover property (pkt_busy && (enable_reg & ~active_reg) != 4'h0 ##1 !pkt_busy);
	c_force_se0: cover property (force_ctl_reg == 8'hFF);
	c_se0_seen: cover property (se0_reg[0] ##1 !se0_reg[0]);
endmodule

// file: rtl/hdpc_sync3.sv
// Three stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module hdpc_sync3 #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					q[i] <= s3_reg[i];
				end
			end
		end
	end
endmodule

// file: sim/hdpc_dev_model.sv
// Downstream devices seen on the four port pin pairs
`timescale 1ns/1ps
module hdpc_dev_model (
	input  wire logic [3:0] dev_drv,
	input  wire logic [3:0] dev_dp,
	input  wire logic [3:0] dev_dm,
	input  wire logic [3:0] dp_out,
	input  wire logic [3:0] dm_out,
	input  wire logic [3:0] dp_oe_n,
	input  wire logic [3:0] dm_oe_n,
	output logic      [3:0] dp_in,
	output logic      [3:0] dm_in
);
	// Hub drive wins; a released pair falls to the pull-down level
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			dp_in[i] = !dp_oe_n[i] ? dp_out[i] : (dev_drv[i] ? dev_dp[i] : 1'b0);
			dm_in[i] = !dm_oe_n[i] ? dm_out[i] : (dev_drv[i] ? dev_dm[i] : 1'b0);
		end
	end
endmodule

// file: sim/tb.sv
// Self-checking bench for the downstream port control block
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] RIDX [4] = '{hdpc_pkg::IDX_ENABLE, hdpc_pkg::IDX_SPEED,
		hdpc_pkg::IDX_FORCE_CTL, hdpc_pkg::IDX_FORCE_LOW};
	logic        clk = 0, rst = 1, usb_bus_reset = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'h0, rx_act = 4'h0, conn_open = 4'h0, p_susp = 4'h0;
	logic        pready, pslverr, err, eof2 = 0, pkt_busy = 0, fs_pkt = 0, dev_susp = 0;
	logic [3:0]  dev_drv = 4'hF, dev_dp = 4'hF, dev_dm = 4'h0, dp_in, dm_in, dp_out, dm_out;
	logic [3:0]  dp_oe_n, dm_oe_n, edge_en, edge_ls, dn_en, up_en;
	logic [3:0]  rep_drv = 4'h0, rep_dpv = 4'h0, rep_dmv = 4'h0;
	integer      n_errors = 0, cmp_count = 0, cyc = 0, seed = 32'h37d3d81c;
	integer      m_en = 0, m_spd = 0, m_fl = 0, r, s, q, v;

	always #10 clk = ~clk;

	hdpc_port_ctrl dut_u (.clk(clk), .rst(rst), .usb_bus_reset(usb_bus_reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .eof2_strobe(eof2),
		.pkt_busy(pkt_busy), .upstream_fs_pkt(fs_pkt), .port_rx_active(rx_act),
		.port_conn_open(conn_open), .port_suspended(p_susp), .dev_suspend(dev_susp),
		.rep_drive(rep_drv), .rep_dp(rep_dpv), .rep_dm(rep_dmv), .port_repeat_down_en(dn_en),
		.port_repeat_up_en(up_en), .dp_in(dp_in), .dm_in(dm_in), .dp_out(dp_out),
		.dm_out(dm_out), .dp_oe_n(dp_oe_n), .dm_oe_n(dm_oe_n), .edge_ctl_en(edge_en),
		.edge_low_speed(edge_ls));
	hdpc_dev_model dev_u (.dev_drv(dev_drv), .dev_dp(dev_dp), .dev_dm(dev_dm), .dp_out(dp_out),
		.dm_out(dm_out), .dp_oe_n(dp_oe_n), .dm_oe_n(dm_oe_n), .dp_in(dp_in), .dm_in(dm_in));

	task automatic results;
		$display("Compares %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors = n_errors + 1;
			results();
		end
	end

	task automatic chk_reg(input logic [31:0] got, input integer exp);
		cmp_count++;
		if (got !== exp[31:0]) begin
			n_errors++;
			$display("Error at %0t: register %h expected %h", $time, got, exp[31:0]);
		end
	endtask

	task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: pins %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] idx, input integer wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		pstrb <= 4'hF;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input integer val);
		apb(1'b1, idx, val);
		if (idx == hdpc_pkg::IDX_ENABLE) m_en = val & 15;
		if (idx == hdpc_pkg::IDX_SPEED) m_spd = val & 15;
		if (idx == hdpc_pkg::IDX_FORCE_LOW) m_fl = val & 255;
	endtask

	task automatic rdc(input logic [7:0] idx, input integer exp);
		apb(1'b0, idx, 0);
		chk_reg(rd, exp);
	endtask

	task automatic tick(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		foreach (RIDX[i]) rdc(RIDX[i], 0);
		apb(1'b0, 8'h4C, 0);
		chk_reg({31'h0, err}, 1);
		for (int k = 0; k < 3; k++) begin
			r = $random(seed) & 15;
			s = $random(seed) & 15;
			q = $random(seed) & 15;
			@(posedge clk);
			dev_dp <= 4'(r);
			dev_dm <= 4'(~r);
			tick(8);
			wr(hdpc_pkg::IDX_DIFF_DATA, 255);
			rdc(hdpc_pkg::IDX_DIFF_DATA, r);
			rdc(hdpc_pkg::IDX_SE0_STAT, 0);
			@(posedge clk);
			dev_dp <= 4'(q & ~s);
			dev_dm <= 4'(~q & ~s);
			tick(8);
			rdc(hdpc_pkg::IDX_DIFF_DATA, (q & ~s | r & s) & 15);
			rdc(hdpc_pkg::IDX_SE0_STAT, s);
		end
		wr(hdpc_pkg::IDX_SPEED, 2);
		pkt_busy <= 1'b1;
		wr(hdpc_pkg::IDX_ENABLE, 255);
		tick(3);
		chk_pin(up_en, 4'h0);
		@(posedge clk);
		pkt_busy <= 1'b0;
		tick(2);
		chk_pin(up_en, 4'hF);
		@(posedge clk);
		fs_pkt <= 1'b1;
		p_susp <= 4'h8;
		rx_act <= 4'h1;
		conn_open <= 4'h4;
		tick(3);
		chk_pin(dn_en, 4'h5);
		chk_pin(up_en, 4'h7);
		@(posedge clk);
		eof2 <= 1'b1;
		@(posedge clk);
		eof2 <= 1'b0;
		rx_act <= 4'h0;
		conn_open <= 4'h0;
		m_en = m_en & 4'hA;
		#1;
		chk_pin(up_en, 4'h2);
		rdc(hdpc_pkg::IDX_ENABLE, m_en);
		r = $random(seed) & 15;
		@(posedge clk);
		rep_drv <= 4'hF;
		rep_dpv <= 4'(r);
		rep_dmv <= 4'(~r);
		tick(2);
		chk_pin(dp_oe_n | dm_oe_n, ~m_en[3:0]);
		chk_pin(dp_out & m_en[3:0], 4'(r & m_en));
		wr(hdpc_pkg::IDX_ENABLE, 0);
		dev_drv <= 4'h0;
		wr(hdpc_pkg::IDX_SPEED, $random(seed));
		for (int p = 0; p < 4; p++) for (int c = 1; c < 4; c++) begin
			wr(hdpc_pkg::IDX_FORCE_CTL, c << (2 * p));
			tick(2);
			chk_pin(dp_oe_n | dm_oe_n, ~(4'h1 << p));
			chk_pin({dp_out[p], dm_out[p], edge_en[p], edge_ls[p]}, {c == 1, c == 2, 1'b1, m_spd[p]});
		end
		wr(hdpc_pkg::IDX_FORCE_CTL, 0);
		dev_susp <= 1'b1;
		wr(hdpc_pkg::IDX_FORCE_LOW, 255);
		tick(8);
		chk_pin(dp_oe_n | dm_oe_n | dp_out | dm_out | edge_en, 4'h0);
		rdc(hdpc_pkg::IDX_SE0_STAT, 15);
		wr(hdpc_pkg::IDX_FORCE_LOW, $random(seed));
		v = m_fl;
		tick(2);
		for (int i = 0; i < 4; i++)
			chk_pin({dp_oe_n[i], dm_oe_n[i], dp_out[i] & ~dp_oe_n[i], dm_out[i] & ~dm_oe_n[i]},
				{~v[2 * i + 1], ~v[2 * i], 2'b00});
		wr(hdpc_pkg::IDX_FORCE_LOW, 8'h55);
		wr(hdpc_pkg::IDX_ENABLE, 3);
		wr(hdpc_pkg::IDX_FORCE_CTL, 8'hC0);
		tick(2);
		chk_pin(dp_oe_n, 4'h7);
		@(posedge clk);
		usb_bus_reset <= 1'b1;
		@(posedge clk);
		usb_bus_reset <= 1'b0;
		m_en = 0;
		m_spd = 0;
		tick(3);
		chk_pin(up_en, 4'h0);
		chk_pin(dp_oe_n, 4'hF);
		chk_pin(dm_oe_n, 4'h0);
		foreach (RIDX[i]) rdc(RIDX[i], i == 3 ? m_fl : 0);
		results();
	end
endmodule
